/* File: rtl/csip_cfg.svh */
/*
  Constants of the camera sensor input port: bus layout, beat tags,
  embedded timing code fields and FIFO sizing.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef CSIP_CFG_SVH
`define CSIP_CFG_SVH

`define CSIP_NUM_PORTS   2
`define CSIP_BUS_W       20
`define CSIP_PIX_W       24
`define CSIP_MODE_W      2
`define CSIP_FMT_W       4
`define CSIP_FIFO_DEPTH  8
// beat = {start of frame, start of line, 20 data lines}
`define CSIP_BEAT_W      22
`define CSIP_TAG_SOF     21
`define CSIP_TAG_SOL     20
// 8-bit lane on data lines 12..19
`define CSIP_LANE_HI     19
`define CSIP_LANE_LO     12
`define CSIP_CODE_PRE    8'hFF
`define CSIP_CODE_ZERO   8'h00
// timing code word bits, seen on the 8-bit lane
`define CSIP_XY_V        17
`define CSIP_XY_H        16
// beats after a start code that carry the code itself
`define CSIP_CODE_SKIP   3'h4

`endif

/* File: rtl/csip_pkg.sv */
/*
  Types of the camera sensor input port: timing modes and pixel formats.
  Assumes nothing of its surroundings.
*/
package csip_pkg;

  typedef enum logic [1:0] {
    CSIP_MODE_BT656,
    CSIP_MODE_BT1120,
    CSIP_MODE_GATED,
    CSIP_MODE_NONGATED
  } csip_mode_t;

  typedef enum logic [3:0] {
    CSIP_FMT_RGB565_2C,
    CSIP_FMT_RGB565_3C,
    CSIP_FMT_RGB666_3C,
    CSIP_FMT_RGB888_3C,
    CSIP_FMT_YC8_2C,
    CSIP_FMT_RGB16,
    CSIP_FMT_YC16,
    CSIP_FMT_YC16_SUB,
    CSIP_FMT_YC20
  } csip_fmt_t;

endpackage : csip_pkg

/* File: rtl/csip_fifo_if.sv */
/*
  Carrier between the pixel-clock capture logic and the input FIFO,
  and between the FIFO and the system-clock pixel assembler.
  Assumes the writer and reader run on different clocks.
*/
`timescale 1ns/10ps
`default_nettype none

interface csip_fifo_if #(parameter int W = 22);
  logic         wr_valid;
  logic [W-1:0] wr_data;
  logic         wr_full;
  logic         rd_valid;
  logic [W-1:0] rd_data;
  logic         rd_pop;

  modport fifo   (input wr_valid, wr_data, rd_pop, output wr_full, rd_valid, rd_data);
  modport writer (output wr_valid, wr_data, input wr_full);
  modport reader (input rd_valid, rd_data, output rd_pop);
endinterface : csip_fifo_if

`default_nettype wire

/* File: rtl/csip_async_fifo.sv */
/*
  Input FIFO of one camera port, written on the pixel clock and read
  on the system clock, with gray-coded pointers crossing by two flops.
  Assumes each side's reset is synchronous to its own clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "csip_cfg.svh"

module csip_async_fifo #(
  parameter int W     = `CSIP_BEAT_W,
  parameter int DEPTH = `CSIP_FIFO_DEPTH
) (
  input  wire logic   wclk_i,
  input  wire logic   wrst_i,
  input  wire logic   rclk_i,
  input  wire logic   rrst_i,
  csip_fifo_if.fifo   f
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least four");
  end
  if (W != $bits(f.wr_data)) begin : g_bad_width
    $error("fifo width differs from carrier width");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin;
  logic [AW:0]  wgray;
  logic [AW:0]  rbin;
  logic [AW:0]  rgray;
  logic [AW:0]  rgray_s1;
  logic [AW:0]  rgray_s2;
  logic [AW:0]  wgray_s1;
  logic [AW:0]  wgray_s2;
  logic [AW:0]  wbin_nx;
  logic [AW:0]  rbin_nx;
  logic         do_wr;
  logic         do_rd;

  assign wbin_nx   = wbin + 1'b1;
  assign rbin_nx   = rbin + 1'b1;
  // full when the write pointer is one lap ahead of the read pointer
  assign f.wr_full = (wgray == {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});
  assign f.rd_valid = (rgray != wgray_s2);
  assign f.rd_data  = mem[rbin[AW-1:0]];
  assign do_wr     = f.wr_valid && !f.wr_full;
  assign do_rd     = f.rd_pop && f.rd_valid;

  // ----------------------------------------------------------------
  // write side
  // ----------------------------------------------------------------
  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      wbin  <= '0;
      wgray <= '0;
    end else if (do_wr) begin
      wbin  <= wbin_nx;
      wgray <= wbin_nx ^ (wbin_nx >> 1);
    end
  end

  always_ff @(posedge wclk_i) begin
    if (do_wr) begin
      mem[wbin[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      rgray_s1 <= '0;
      rgray_s2 <= '0;
    end else begin
      rgray_s1 <= rgray;
      rgray_s2 <= rgray_s1;
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (do_rd) begin
      rbin  <= rbin_nx;
      rgray <= rbin_nx ^ (rbin_nx >> 1);
    end
  end

  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      wgray_s1 <= '0;
      wgray_s2 <= '0;
    end else begin
      wgray_s1 <= wgray;
      wgray_s2 <= wgray_s1;
    end
  end

endmodule : csip_async_fifo

`default_nettype wire

/* File: rtl/csip_top.sv */
/*
  Camera sensor input ports: capture on each sensor pixel clock,
  embedded-code or sync-pin framing, input FIFO, pixel assembly on mclk_i.
  Assumes the sensor drives data and syncs synchronous to its pixel clock,
  and that configuration changes only while the sensor is idle.
// How it works
// R1 - three timing modes: embedded, gated, non-gated
// R2 - embedded mode: framing travels inside data
// R3 - active line runs from start to end code
// R4 - blanking between codes is never captured
// R5 - codes removed, frame and line starts regenerated
// R6 - 656 one component, 1120 two per cycle
// R7 - gated frame starts on frame sync edge
// R8 - gated clocks valid only while line sync active
// R9 - gated data latched on valid clock edge
// R10 - line sync inactive stops capture until next line
// R11 - non-gated ignores line sync, captures every clock
// R12 - sensor holds pixel clock low until data
// R13 - programmable frame edge, line level, clock edge
// R14 - three-cycle 565 components extended by msb copies
// R15 - three-cycle 666 components extended by two msbs
// R16 - rgb16 raw, or processed under gated protocol
// R17 - one-cycle luma/chroma 16 bits raw only
// R18 - 20-bit luma/chroma only in 1120 mode
// R19 - 16-bit sub-case handled like 20-bit 1120
// R20 - 8-bit lane lines 12..19; rgb16 lines 4..19
// R21 - two independent ports with own pins, config
*/
`timescale 1ns/10ps
`default_nettype none
`include "csip_cfg.svh"

module csip_top #(
  parameter int PORTS      = `CSIP_NUM_PORTS,
  parameter int FIFO_DEPTH = `CSIP_FIFO_DEPTH
) (
  input  wire logic                                   mclk_i,
  input  wire logic                                   rst_i,
  input  wire logic [PORTS-1:0]                       sensor_pixel_clock_i,
  input  wire logic [PORTS-1:0]                       frame_sync_in_i,
  input  wire logic [PORTS-1:0]                       line_sync_in_i,
  input  wire logic [PORTS-1:0][`CSIP_BUS_W-1:0]      sensor_pixel_bus_i,
  input  wire logic [PORTS-1:0]                       port_enable_i,
  input  wire logic [PORTS-1:0][`CSIP_MODE_W-1:0]     timing_mode_i,
  input  wire logic [PORTS-1:0][`CSIP_FMT_W-1:0]      pixel_format_i,
  input  wire logic [PORTS-1:0]                       frame_sync_falling_i,
  input  wire logic [PORTS-1:0]                       line_sync_active_low_i,
  input  wire logic [PORTS-1:0]                       pixel_clock_falling_i,
  input  wire logic [PORTS-1:0]                       rgb16_process_i,
  output logic      [PORTS-1:0][`CSIP_PIX_W-1:0]      pixel_o,
  output logic      [PORTS-1:0]                       pixel_valid_o,
  output logic      [PORTS-1:0]                       frame_start_o,
  output logic      [PORTS-1:0]                       line_start_o,
  output logic      [PORTS-1:0]                       fifo_overflow_o,
  output logic      [PORTS-1:0]                       format_error_o
);
  localparam int BW = `CSIP_BEAT_W;

  // R21 two ports by default
  if (PORTS < 1) begin : g_bad_ports
    $error("at least one camera port is needed");
  end

  // clock edge choice feeds a clock xor: flop it so the clock sees no comb glitch
  logic [PORTS-1:0] pclk_fall_q;

  always_ff @(posedge mclk_i) pclk_fall_q <= rst_i ? '0 : pixel_clock_falling_i;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    // --------------------------------------------------------------
    // link side: runs on the sensor pixel clock
    // --------------------------------------------------------------
    logic                        lclk, lrst_s1, lrst, en_l, fs_fall_l, ls_low_l;
    logic [4:0]                  cfg_s1, cfg_s2;
    csip_pkg::csip_mode_t        mode_l;
    logic [`CSIP_BUS_W-1:0]      din, cap;
    logic                        fs_in, fs_prev, ls_in, ls_prev, frame_edge;
    logic [3:0][`CSIP_BUS_W-1:0] dly;
    logic                        embedded, code_hit, sav, eav, active, vblank;
    logic [2:0]                  skip;
    logic                        beat_ok, set_sof, set_sol, sof_pend, sol_pend;
    logic                        wr_valid_l, ovf_l;
    logic [BW-1:0]               wr_data_l;

    csip_fifo_if #(.W(BW)) fifo_bus ();

    // R13 capture edge chosen by inverting the pixel clock
    assign lclk = sensor_pixel_clock_i[p] ^ pclk_fall_q[p];

    // pixel clock may stand still: link reset needs a few clock edges
    always_ff @(posedge lclk) begin
      lrst_s1 <= rst_i;
      lrst    <= lrst_s1;
    end

    always_ff @(posedge lclk) begin
      if (lrst) begin
        cfg_s1 <= '0;
        cfg_s2 <= '0;
      end else begin
        cfg_s1 <= {port_enable_i[p], timing_mode_i[p],
                   frame_sync_falling_i[p], line_sync_active_low_i[p]};
        cfg_s2 <= cfg_s1;
      end
    end

    assign en_l      = cfg_s2[4];
    assign mode_l    = csip_pkg::csip_mode_t'(cfg_s2[3:2]);
    assign fs_fall_l = cfg_s2[1];
    assign ls_low_l  = cfg_s2[0];

    // R9 data latched on each capture edge, R13 sync polarities applied
    always_ff @(posedge lclk) begin
      if (lrst) begin
        din     <= '0;
        fs_in   <= 1'b0;
        fs_prev <= 1'b0;
        ls_in   <= 1'b0;
        ls_prev <= 1'b0;
      end else begin
        din     <= sensor_pixel_bus_i[p];
        fs_in   <= frame_sync_in_i[p] ^ fs_fall_l;
        fs_prev <= fs_in;
        ls_in   <= line_sync_in_i[p] ^ ls_low_l;
        ls_prev <= ls_in;
      end
    end

    always_ff @(posedge lclk) dly <= lrst ? '0 : {dly[2:0], din};

    // R7 frame begins on active edge of frame sync
    assign frame_edge = fs_in & ~fs_prev;

    // R2 embedded modes take framing from the data only
    assign embedded = (mode_l == csip_pkg::CSIP_MODE_BT656) ||
                      (mode_l == csip_pkg::CSIP_MODE_BT1120);
    // R20 codes seen on the 8-bit lane, top of luma in 1120
    assign code_hit = embedded &&
                      (dly[2][`CSIP_LANE_HI:`CSIP_LANE_LO] == `CSIP_CODE_PRE) &&
                      (dly[1][`CSIP_LANE_HI:`CSIP_LANE_LO] == `CSIP_CODE_ZERO) &&
                      (dly[0][`CSIP_LANE_HI:`CSIP_LANE_LO] == `CSIP_CODE_ZERO);
    assign sav = code_hit & ~din[`CSIP_XY_H];
    assign eav = code_hit & din[`CSIP_XY_H];

    // R3 line opens at start code, closes at end code
    always_ff @(posedge lclk) begin
      if (lrst) begin
        active <= 1'b0;
      end else if (eav) begin
        active <= 1'b0;
      end else if (sav) begin
        active <= ~din[`CSIP_XY_V];
      end
    end

    always_ff @(posedge lclk) begin
      if (lrst) begin
        vblank <= 1'b1;
      end else if (sav & ~din[`CSIP_XY_V]) begin
        vblank <= 1'b0;
      end else if (code_hit & din[`CSIP_XY_V]) begin
        vblank <= 1'b1;
      end
    end

    // R5 the start code words still in the delay line are dropped
    always_ff @(posedge lclk) begin
      if (lrst) begin
        skip <= 3'h0;
      end else if (sav & ~din[`CSIP_XY_V]) begin
        skip <= `CSIP_CODE_SKIP;
      end else if (skip != 3'h0) begin
        skip <= skip - 3'h1;
      end
    end

    // R1 mode selects what makes a beat valid
    always_comb begin
      beat_ok = 1'b0;
      cap     = din;
      set_sof = frame_edge;
      set_sol = ls_in & ~ls_prev;
      case (mode_l)
        csip_pkg::CSIP_MODE_BT656,
        csip_pkg::CSIP_MODE_BT1120: begin
          // R4 blanking outside an active line never written
          beat_ok = active && (skip == 3'h0);
          cap     = dly[3];
          // R5 frame and line starts rebuilt from the codes
          set_sof = sav & ~din[`CSIP_XY_V] & vblank;
          set_sol = sav & ~din[`CSIP_XY_V];
        end
        csip_pkg::CSIP_MODE_GATED: begin
          // R8 R10 clocks count only while line sync active
          beat_ok = ls_in;
        end
        csip_pkg::CSIP_MODE_NONGATED: begin
          // R11 R12 every clock edge carries a pixel
          beat_ok = 1'b1;
          set_sol = frame_edge;
        end
        default: beat_ok = 1'b0;
      endcase
      beat_ok = beat_ok & en_l;
    end

    // start tags wait for the next captured beat; a start is lost only if a full FIFO drops that beat
    always_ff @(posedge lclk) begin
      if (lrst) begin
        sof_pend <= 1'b0;
        sol_pend <= 1'b0;
      end else begin
        sof_pend <= (sof_pend | set_sof) & ~beat_ok;
        sol_pend <= (sol_pend | set_sol) & ~beat_ok;
      end
    end

    // R11 captured beats go into the input FIFO
    always_ff @(posedge lclk) begin
      if (lrst) begin
        wr_valid_l <= 1'b0;
        wr_data_l  <= '0;
      end else begin
        wr_valid_l <= beat_ok;
        wr_data_l  <= {sof_pend | set_sof, sol_pend | set_sol, cap};
      end
    end

    // no back-pressure toward a sensor: a full FIFO drops and flags it
    always_ff @(posedge lclk) ovf_l <= !lrst && (ovf_l || (wr_valid_l && fifo_bus.wr_full));

    assign fifo_bus.wr_valid = wr_valid_l;
    assign fifo_bus.wr_data  = wr_data_l;

    csip_async_fifo #(.W(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .wclk_i(lclk), .wrst_i(lrst), .rclk_i(mclk_i), .rrst_i(rst_i), .f(fifo_bus.fifo));

    // --------------------------------------------------------------
    // system side: pixel assembly on mclk_i
    // --------------------------------------------------------------
    csip_pkg::csip_mode_t   mode_m;
    csip_pkg::csip_fmt_t    fmt_m;
    logic                   ovf_s1, ovf_s2, pop, last, legal, proc16;
    logic [`CSIP_BUS_W-1:0] d;
    logic [7:0]             lane, b0, b1;
    logic [1:0]             phase, cur_phase, need;
    logic                   acc_sof, acc_sol, f_sof, f_sol;
    logic [`CSIP_PIX_W-1:0] pix;

    assign mode_m = csip_pkg::csip_mode_t'(timing_mode_i[p]);
    assign fmt_m  = csip_pkg::csip_fmt_t'(pixel_format_i[p]);
    // the assembler never stalls, so the FIFO drains one beat a cycle
    assign pop    = fifo_bus.rd_valid;
    assign fifo_bus.rd_pop = pop;
    assign d      = fifo_bus.rd_data[`CSIP_BUS_W-1:0];
    assign lane   = d[`CSIP_LANE_HI:`CSIP_LANE_LO];
    // a line start realigns the component phase
    assign cur_phase = fifo_bus.rd_data[`CSIP_TAG_SOL] ? 2'h0 : phase;
    assign last   = (cur_phase == need - 2'h1);
    assign f_sof  = fifo_bus.rd_data[`CSIP_TAG_SOF] | ((cur_phase != 2'h0) & acc_sof);
    assign f_sol  = fifo_bus.rd_data[`CSIP_TAG_SOL] | ((cur_phase != 2'h0) & acc_sol);
    // R16 processing only under the gated sync protocol
    assign proc16 = rgb16_process_i[p] && (mode_m == csip_pkg::CSIP_MODE_GATED);

    // R6 R17 R18 R19 format legal only in a fitting mode
    always_comb begin
      need  = 2'h1;
      legal = 1'b0;
      case (fmt_m)
        csip_pkg::CSIP_FMT_RGB565_2C,
        csip_pkg::CSIP_FMT_YC8_2C: begin
          need  = 2'h2;
          legal = (mode_m != csip_pkg::CSIP_MODE_BT1120);
        end
        csip_pkg::CSIP_FMT_RGB565_3C,
        csip_pkg::CSIP_FMT_RGB666_3C,
        csip_pkg::CSIP_FMT_RGB888_3C: begin
          need  = 2'h3;
          legal = (mode_m != csip_pkg::CSIP_MODE_BT1120);
        end
        csip_pkg::CSIP_FMT_RGB16,
        csip_pkg::CSIP_FMT_YC16:     legal = (mode_m > csip_pkg::CSIP_MODE_BT1120);
        csip_pkg::CSIP_FMT_YC16_SUB,
        csip_pkg::CSIP_FMT_YC20:     legal = (mode_m == csip_pkg::CSIP_MODE_BT1120);
        default:                     legal = 1'b0;
      endcase
    end

    // R20 lane and line positions per format
    always_comb begin
      pix = '0;
      case (fmt_m)
        csip_pkg::CSIP_FMT_RGB565_2C:
          pix = {lane[7:3], 3'h0, lane[2:0], b0[7:5], 2'h0, b0[4:0], 3'h0};
        // R14 five and six bit components widened by msb copies
        csip_pkg::CSIP_FMT_RGB565_3C:
          pix = {b0[7:3], b0[7:5], b1[7:2], b1[7:6], lane[7:3], lane[7:5]};
        // R15 two msbs copied into the two lsbs
        csip_pkg::CSIP_FMT_RGB666_3C:
          pix = {b0[7:2], b0[7:6], b1[7:2], b1[7:6], lane[7:2], lane[7:6]};
        csip_pkg::CSIP_FMT_RGB888_3C: pix = {b0, b1, lane};
        csip_pkg::CSIP_FMT_YC8_2C:    pix = {8'h00, lane, b0};
        // R16 raw generic data unless processing applies
        csip_pkg::CSIP_FMT_RGB16:
          pix = proc16 ? {d[19:15], d[19:17], d[14:9], d[14:13], d[8:4], d[8:6]} : {8'h00, d[19:4]};
        // R17 luma high, chroma low, passed raw
        csip_pkg::CSIP_FMT_YC16:      pix = {8'h00, d[19:4]};
        // R19 lowest lines of each half forced to zero
        csip_pkg::CSIP_FMT_YC16_SUB:  pix = {4'h0, d[19:12], 2'h0, d[9:2], 2'h0};
        // R18 luma 10 bits on top, chroma 10 bits below
        csip_pkg::CSIP_FMT_YC20:      pix = {4'h0, d};
        default:                      pix = '0;
      endcase
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        phase   <= 2'h0;
        b0      <= 8'h00;
        b1      <= 8'h00;
        acc_sof <= 1'b0;
        acc_sol <= 1'b0;
      end else if (pop) begin
        phase   <= last ? 2'h0 : cur_phase + 2'h1;
        acc_sof <= f_sof;
        acc_sol <= f_sol;
        if (cur_phase == 2'h0) begin
          b0 <= lane;
        end
        if (cur_phase == 2'h1) begin
          b1 <= lane;
        end
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        pixel_o[p]       <= '0;
        pixel_valid_o[p] <= 1'b0;
        frame_start_o[p] <= 1'b0;
        line_start_o[p]  <= 1'b0;
      end else begin
        pixel_valid_o[p] <= pop & last & legal;
        frame_start_o[p] <= pop & last & legal & f_sof;
        line_start_o[p]  <= pop & last & legal & f_sol;
        if (pop & last & legal) begin
          pixel_o[p] <= pix;
        end
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        ovf_s1             <= 1'b0;
        ovf_s2             <= 1'b0;
        fifo_overflow_o[p] <= 1'b0;
        format_error_o[p]  <= 1'b0;
      end else begin
        ovf_s1             <= ovf_l;
        ovf_s2             <= ovf_s1;
        fifo_overflow_o[p] <= ovf_s2;
        format_error_o[p]  <= ~legal;
      end
    end
  end

endmodule : csip_top

`default_nettype wire

/* File: verif/csip_sensor_model.sv */
/* Image sensor model for one port: pixel clock runs only while sending.
   Assumes the bench fills q, sets inv_fs and inv_ls, and calls play. */
`timescale 1ns/10ps
`default_nettype none
module csip_sensor_model (
  output var logic        pclk_o,
  output var logic        fs_o,
  output var logic        ls_o,
  output var logic [19:0] bus_o
);
  // ----------------
  // line playback
  // ----------------
  logic [19:0] q[$];
  logic        inv_fs = 1'h0;
  logic        inv_ls = 1'h0;
  initial {pclk_o, fs_o, ls_o, bus_o} = '0;
  task automatic edges(input int n);
    repeat (n) begin
      #8 pclk_o = 1'h1;
      #16 pclk_o = 1'h0;
      #8;
    end
  endtask : edges
  task automatic play(input int pre, input logic gate);
    fs_o = inv_fs;
    ls_o = inv_ls;
    edges(pre);
    // frame edge, line sync held active over the line only when gate is set
    fs_o = ~inv_fs;
    ls_o = gate ^ inv_ls;
    while (q.size() > 0) begin
      bus_o = q.pop_front();
      edges(1);
    end
    fs_o = inv_fs;
    ls_o = inv_ls;
    // released bus no longer shows the last word
    bus_o = ~bus_o;
    edges(3);
  endtask : play
endmodule : csip_sensor_model
`default_nettype wire

/* File: verif/csip_top_monitor.sv */
/* Port 0 checker of csip_top, bound into every instance.
   Assumes all outputs are registers on mclk_i, rst_i synchronous. */
`timescale 1ns/10ps
`default_nettype none
module csip_top_monitor #(parameter int PORTS = 2) (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic [PORTS-1:0][1:0]  timing_mode_i,
  input wire logic [PORTS-1:0][3:0]  pixel_format_i,
  input wire logic [PORTS-1:0][23:0] pixel_o,
  input wire logic [PORTS-1:0]       pixel_valid_o,
  input wire logic [PORTS-1:0]       frame_start_o,
  input wire logic [PORTS-1:0]       line_start_o,
  input wire logic [PORTS-1:0]       fifo_overflow_o
  ,input wire logic [PORTS-1:0]      format_error_o
);
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_cfg(m, f);
    (timing_mode_i[0] == m && pixel_format_i[0] == f) [*2];
  endsequence
  property p_fs; frame_start_o[0] |-> pixel_valid_o[0] && line_start_o[0]; endproperty
  property p_ls; line_start_o[0] |-> pixel_valid_o[0]; endproperty
  property p_one; pixel_valid_o[0] |=> !pixel_valid_o[0]; endproperty
  property p_sticky; fifo_overflow_o[0] |=> fifo_overflow_o[0]; endproperty
  property p_bad; s_cfg(2'h2, 4'hF) |-> format_error_o[0]; endproperty
  property p_656; s_cfg(2'h0, 4'h8) |-> format_error_o[0]; endproperty
  property p_yc16; s_cfg(2'h1, 4'h6) |-> format_error_o[0]; endproperty
  property p_rgb16; s_cfg(2'h2, 4'h5) |-> !format_error_o[0]; endproperty
  property p_hold; !pixel_valid_o[0] |-> $stable(pixel_o[0]); endproperty
  a_fs: assert property (p_fs) else $error("frame start off a line start");
  a_ls: assert property (p_ls) else $error("line start without pixel");
  a_one: assert property (p_one) else $error("pixel pulse too long");
  a_sticky: assert property (p_sticky) else $error("overflow cleared");
  a_bad: assert property (p_bad) else $error("bad format accepted");
  a_656: assert property (p_656) else $error("wide format in 656");
  a_yc16: assert property (p_yc16) else $error("raw format in 1120");
  a_rgb16: assert property (p_rgb16) else $error("rgb16 refused");
  a_hold: assert property (p_hold) else $error("pixel moved idle");
endmodule : csip_top_monitor
bind csip_top csip_top_monitor #(.PORTS(PORTS)) u_mon (.mclk_i, .rst_i, .timing_mode_i,
  .pixel_format_i, .pixel_o, .pixel_valid_o, .frame_start_o, .line_start_o, .fifo_overflow_o,
  .format_error_o);
`default_nettype wire

/* File: verif/tb_camera_sensor_input_port.sv */
/* Bench of csip_top: table of one-pixel lines, refusals, polarity, reset.
   Assumes one sensor model per port on the sensor pins. */
`timescale 1ns/10ps
`default_nettype none
module tb_camera_sensor_input_port;
  typedef struct packed {
    logic [1:0] m; logic [3:0] f; logic p; logic [1:0] n; logic [59:0] d; logic [23:0] e;
  } csip_row_t;
  // ----------------
  // table and pins
  // ----------------
  // bytes on lines 19..12, wide words on 19..0
  localparam csip_row_t ROWS [12] = '{
    '{2'h2,4'h1,1'h0,2'h3,60'h88000_44000_33000,24'h8C4531},
    '{2'h2,4'h2,1'h0,2'h3,60'h88000_44000_33000,24'h8A4530},
    '{2'h2,4'h3,1'h0,2'h3,60'h88000_44000_33000,24'h884433},
    '{2'h2,4'h4,1'h0,2'h2,60'h5A000_C3000_00000,24'h00C35A},
    '{2'h2,4'h0,1'h0,2'h2,60'h88000_44000_00000,24'h409040},
    '{2'h2,4'h5,1'h0,2'h1,60'hABCD0_00000_00000,24'h00ABCD},
    '{2'h2,4'h5,1'h1,2'h1,60'hABCD0_00000_00000,24'hAD796B},
    '{2'h2,4'h6,1'h0,2'h1,60'h12340_00000_00000,24'h001234},
    '{2'h0,4'h4,1'h0,2'h2,60'h5A000_C3000_00000,24'h00C35A},
    '{2'h1,4'h8,1'h0,2'h1,60'hABCDE_00000_00000,24'h0ABCDE},
    '{2'h1,4'h7,1'h0,2'h1,60'hAB3DC_00000_00000,24'h0AB3DC},
    '{2'h3,4'h3,1'h0,2'h3,60'h88000_44000_33000,24'h884433}};
  localparam csip_row_t REFU [4] = '{
    '{2'h2,4'hF,1'h0,2'h3,60'h88000_44000_33000,24'h1},
    '{2'h0,4'h8,1'h0,2'h1,60'hABCDE_00000_00000,24'h1},
    '{2'h1,4'h6,1'h0,2'h1,60'h12340_00000_00000,24'h1},
    '{2'h2,4'h3,1'h0,2'h3,60'h88000_44000_33000,24'h0}};
  logic             mclk_i, rst_i, got;
  logic [1:0]       port_enable_i, frame_sync_falling_i, line_sync_active_low_i;
  logic [1:0]       pixel_clock_falling_i, rgb16_process_i;
  logic [1:0][1:0]  timing_mode_i;
  logic [1:0][3:0]  pixel_format_i;
  logic [1:0][23:0] pixel_o;
  logic [1:0]       pixel_valid_o, frame_start_o, line_start_o, fifo_overflow_o, format_error_o;
  wire [1:0]        sensor_pixel_clock_i, frame_sync_in_i, line_sync_in_i;
  wire [1:0][19:0]  sensor_pixel_bus_i;
  logic [24:0]      cap;
  int               bad_count = 0, checks_done = 0, cycles = 0, p1_hits = 0;
  csip_top #(.FIFO_DEPTH(4)) uut (.mclk_i, .rst_i, .sensor_pixel_clock_i, .frame_sync_in_i,
    .line_sync_in_i, .sensor_pixel_bus_i, .port_enable_i, .timing_mode_i, .pixel_format_i,
    .frame_sync_falling_i, .line_sync_active_low_i, .pixel_clock_falling_i, .rgb16_process_i,
    .pixel_o, .pixel_valid_o, .frame_start_o, .line_start_o, .fifo_overflow_o, .format_error_o);
  csip_sensor_model m0 (.pclk_o(sensor_pixel_clock_i[0]), .fs_o(frame_sync_in_i[0]),
    .ls_o(line_sync_in_i[0]), .bus_o(sensor_pixel_bus_i[0]));
  csip_sensor_model m1 (.pclk_o(sensor_pixel_clock_i[1]), .fs_o(frame_sync_in_i[1]),
    .ls_o(line_sync_in_i[1]), .bus_o(sensor_pixel_bus_i[1]));
  task automatic chk(input logic [24:0] g, input logic [24:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic codes(input logic [7:0] xy);
    m0.q.push_back(20'hFF000);
    m0.q.push_back(20'h00000);
    m0.q.push_back(20'h00000);
    m0.q.push_back({xy, 12'h000});
  endtask : codes
  // first pixel carrying a line start, window long enough to drain
  task automatic wait_pix();
    got = 1'h0;
    cap = '0;
    repeat (150) begin
      @(posedge mclk_i);
      #1;
      if (!got && pixel_valid_o[0] === 1'h1 && line_start_o[0] === 1'h1) begin
        got = 1'h1;
        cap = {frame_start_o[0], pixel_o[0]};
      end
    end
  endtask : wait_pix
  task automatic run_row(input csip_row_t r, input logic en);
    @(posedge mclk_i);
    port_enable_i <= {2{en}};
    timing_mode_i[0] <= r.m;
    pixel_format_i[0] <= r.f;
    rgb16_process_i <= {2{r.p}};
    @(posedge mclk_i);
    // blanking code, start code, pixels, end code, blanking word
    if (r.m < 2'h2) begin
      codes(8'hB0);
      codes(8'h80);
    end
    for (int i = 0; i < r.n; i++) m0.q.push_back(r.d[59-20*i -: 20]);
    if (r.m < 2'h2) begin
      codes(8'h90);
      m0.q.push_back(20'h10000);
    end
    fork
      m0.play(3, r.m == 2'h2);
      wait_pix();
    join
    $display("case mode %0d format %0d done", r.m, r.f);
  endtask : run_row
  initial begin
    mclk_i = 1'h0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (pixel_valid_o[1] === 1'h1) p1_hits++;
    if (cycles == 10000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    rst_i = 1'h1;
    port_enable_i = 2'h3;
    timing_mode_i = {2'h2, 2'h2};
    pixel_format_i = {4'h3, 4'h3};
    {frame_sync_falling_i, line_sync_active_low_i} = '0;
    {pixel_clock_falling_i, rgb16_process_i} = '0;
    fork
      m0.edges(5);
      m1.edges(5);
      repeat (20) @(posedge mclk_i);
    join
    rst_i <= 1'h0;
    foreach (ROWS[i]) begin
      run_row(ROWS[i], 1'h1);
      chk(cap, {1'h1, ROWS[i].e});
    end
    foreach (REFU[i]) begin
      run_row(REFU[i], REFU[i].e[0]);
      chk({got, format_error_o[0]}, {1'h0, REFU[i].e[0]});
    end
    @(posedge mclk_i);
    {frame_sync_falling_i, line_sync_active_low_i, pixel_clock_falling_i} <= '1;
    {m0.inv_fs, m0.inv_ls} = 2'h3;
    run_row(ROWS[2], 1'h1);
    chk(cap, {1'h1, ROWS[2].e});
    chk(25'(p1_hits), 25'h0);
    chk({24'h0, fifo_overflow_o[0]}, 25'h0);
    @(posedge mclk_i) rst_i <= 1'h1;
    fork
      m0.edges(4);
      repeat (4) @(posedge mclk_i);
    join
    chk({pixel_o[0], pixel_valid_o[0]}, 25'h0);
    $display("reset case done");
    conclude();
  end
endmodule : tb_camera_sensor_input_port
`default_nettype wire
